//--- logic/feac_transmit_controller.sv
// four-port FEAC codeword transmitter with its APB register file
// How it works
// R1 - each port's five registers sit at C0h to C8h in steps of two under port nibble 0, 2, 4 or 6.
// R2 - a 0 to 1 write of the load bit copies mode and both codes into the engine; nothing else does.
// R3 - a load aborts the running sequence at once and starts over with the new values.
// R4 - mode 00 sends only all ones.
// R5 - mode 01 sends the first code ten times, then all ones.
// R6 - mode 10 sends the first code ten times, the second ten times, then all ones.
// R7 - mode 11 repeats the first code until the next load.
// R8 - the second code lives in bits 13 to 8, bit 8 sent first.
// R9 - the first code lives in bits 5 to 0, bit 0 sent first.
// R10 - status bit 0 reads 1 while all ones go out and 0 while a codeword does.
// R11 - latched bit 0 sets when the idle status rises.
// R12 - the latched idle bit is one straight out of reset.
// R13 - a codeword is zero, six code bits, zero, eight ones, one bit per framer opportunity.
// R14 - the latched idle bit clears only by writing a one to it.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module feac_transmit_controller
  import feac_tx_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire apb_req_t              apb_req,
  output apb_rsp_t                   apb_rsp,
  input  wire logic [PORT_COUNT-1:0] bit_opportunity,
  output logic [PORT_COUNT-1:0]      feac_bit
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       hit;
    logic       used;
    logic [1:0] port;
    logic [7:0] sel;
  } dec_t;

  function automatic dec_t decode(input logic [31:0] addr);
    dec_t       d;
    logic [11:0] idx;
    idx    = addr[IDX_LSB+11:IDX_LSB];
    d.port = idx[10:9];
    d.sel  = idx[7:0];
    d.hit  = (addr[31:IDX_LSB+12] == 18'h00000) && (addr[1:0] == 2'h0)
             && !idx[11] && !idx[8] && (idx[7:4] == BLOCK_NIBBLE) && !idx[0]; // [R1]
    d.used = d.hit && (idx[7:0] <= TX_IRQ_EN_IDX);
    return d;
  endfunction

  function automatic logic codeword_bit(input logic [5:0] code, input logic [3:0] pos);
    logic b;
    b = 1'b1;
    if (pos == 4'h0 || pos == TRAIL_ZERO_POS) begin
      b = 1'b0; // [R13]
    end else if (pos >= FIRST_CODE_POS && pos <= LAST_CODE_POS) begin
      b = code[3'(pos - FIRST_CODE_POS)]; // [R8] [R9]
    end
    return b;
  endfunction

  dec_t       dec;
  logic       wr_access;
  assign dec       = decode(apb_req.paddr);
  assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // ---------------------------------------------------------------
  // register file and engines
  // ---------------------------------------------------------------
  port_regs_t [PORT_COUNT-1:0] regs_reg;
  port_regs_t [PORT_COUNT-1:0] regs_next;
  eng_t       [PORT_COUNT-1:0] eng_reg;
  eng_t       [PORT_COUNT-1:0] eng_next;
  logic       [PORT_COUNT-1:0] bit_reg;
  logic       [PORT_COUNT-1:0] bit_next;
  logic       [PORT_COUNT-1:0] load;
  logic       [PORT_COUNT-1:0] idle;
  logic       [31:0]           prdata_reg;
  logic       [31:0]           prdata_next;
  logic                        pslverr_reg;
  logic                        pslverr_next;

  always_comb begin
    regs_next = regs_reg;
    eng_next  = eng_reg;
    bit_next  = bit_reg;
    for (int i = 0; i < PORT_COUNT; i++) begin
      idle[i] = (eng_reg[i].state == ENG_IDLE); // [R10]
      load[i] = wr_access && dec.hit && (dec.port == 2'(i)) && (dec.sel == TX_CONTROL_IDX)
                && apb_req.pwdata[LOAD_BIT] && !regs_reg[i].tx_control_reg[LOAD_BIT]; // [R2]
      regs_next[i].idle_prev = idle[i];
      if (wr_access && dec.hit && dec.port == 2'(i)) begin
        unique case (dec.sel)
          TX_CONTROL_IDX: regs_next[i].tx_control_reg = apb_req.pwdata[15:0] & CONTROL_MASK;
          TX_CODE_IDX:    regs_next[i].tx_code_reg    = apb_req.pwdata[15:0] & CODE_MASK;
          TX_IRQ_EN_IDX:  regs_next[i].tx_state_irq_enable_reg =
                            apb_req.pwdata[15:0] & IRQ_EN_MASK;
          TX_LATCHED_IDX: begin
            if (apb_req.pwdata[IDLE_BIT]) begin
              regs_next[i].tx_idle_latched = 1'b0; // [R14]
            end
          end
          default: ;
        endcase
      end
      // set wins over a clear in the same cycle
      if (idle[i] && !regs_reg[i].idle_prev) begin
        regs_next[i].tx_idle_latched = 1'b1; // [R11]
      end
      // ---- serializer
      if (bit_opportunity[i]) begin
        unique case (eng_reg[i].state)
          ENG_IDLE:   bit_next[i] = 1'b1; // [R4]
          ENG_CODE_A: bit_next[i] = codeword_bit(eng_reg[i].first_code, eng_reg[i].bit_pos);
          ENG_CODE_B: bit_next[i] = codeword_bit(eng_reg[i].second_code, eng_reg[i].bit_pos);
          default:    bit_next[i] = 1'b1;
        endcase
        if (eng_reg[i].state != ENG_IDLE) begin
          if (eng_reg[i].bit_pos == LAST_BIT_POS) begin
            eng_next[i].bit_pos = 4'h0;
            if (eng_reg[i].mode != MODE_CONT) begin // [R7]
              if (eng_reg[i].rep_cnt == CODE_REPEATS - 4'h1) begin
                eng_next[i].rep_cnt = 4'h0;
                if (eng_reg[i].state == ENG_CODE_A && eng_reg[i].mode == MODE_DUAL) begin
                  eng_next[i].state = ENG_CODE_B; // [R6]
                end else begin
                  eng_next[i].state = ENG_IDLE; // [R5] [R6]
                end
              end else begin
                eng_next[i].rep_cnt = eng_reg[i].rep_cnt + 4'h1;
              end
            end
          end else begin
            eng_next[i].bit_pos = eng_reg[i].bit_pos + 4'h1; // [R13]
          end
        end
      end
      // a load overrides any progress made this cycle
      if (load[i]) begin
        eng_next[i].mode        = seq_mode_t'(regs_reg[i].tx_control_reg[MODE_LSB +: 2]); // [R2]
        eng_next[i].first_code  = regs_reg[i].tx_code_reg[FIRST_CODE_LSB +: 6];
        eng_next[i].second_code = regs_reg[i].tx_code_reg[SECOND_CODE_LSB +: 6];
        eng_next[i].bit_pos     = 4'h0; // [R3]
        eng_next[i].rep_cnt     = 4'h0;
        eng_next[i].state       = (regs_reg[i].tx_control_reg[MODE_LSB +: 2] == MODE_IDLE)
                                  ? ENG_IDLE : ENG_CODE_A; // [R3] [R4]
      end
    end
  end

  // ---------------------------------------------------------------
  // apb read path: data captured in setup, answered in access
  // ---------------------------------------------------------------
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (apb_req.psel && !apb_req.penable) begin
      prdata_next  = 32'h00000000;
      pslverr_next = !dec.hit;
      if (dec.used && !apb_req.pwrite) begin
        unique case (dec.sel)
          TX_CONTROL_IDX: prdata_next[15:0] = regs_reg[dec.port].tx_control_reg;
          TX_CODE_IDX:    prdata_next[15:0] = regs_reg[dec.port].tx_code_reg;
          TX_STATE_IDX:   prdata_next[IDLE_BIT] = idle[dec.port]; // [R10]
          TX_LATCHED_IDX: prdata_next[IDLE_BIT] = regs_reg[dec.port].tx_idle_latched;
          TX_IRQ_EN_IDX:  prdata_next[15:0] = regs_reg[dec.port].tx_state_irq_enable_reg;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PORT_COUNT; i++) begin
        regs_reg[i].tx_control_reg          <= CONTROL_RESET;
        regs_reg[i].tx_code_reg             <= CODE_RESET;
        regs_reg[i].tx_state_irq_enable_reg <= IRQ_EN_RESET;
        regs_reg[i].tx_idle_latched         <= LATCHED_RESET; // [R12]
        regs_reg[i].idle_prev               <= 1'b1;
        eng_reg[i]                          <= '0;
      end
      bit_reg     <= '1;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      regs_reg    <= regs_next;
      eng_reg     <= eng_next;
      bit_reg     <= bit_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign feac_bit        = bit_reg;
  assign apb_rsp.prdata  = prdata_reg;
  assign apb_rsp.pslverr = pslverr_reg && apb_req.psel && apb_req.penable;
  // zero wait states keep the master's access phase to one cycle
  assign apb_rsp.pready  = apb_req.psel && apb_req.penable;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  for (genvar g = 0; g < PORT_COUNT; g++) begin : g_chk
    sequence last_word_bit;
      bit_opportunity[g] && !load[g] && eng_reg[g].bit_pos == LAST_BIT_POS
        && eng_reg[g].rep_cnt == CODE_REPEATS - 4'h1;
    endsequence

    a_load_restarts: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
      load[g] |=> eng_reg[g].bit_pos == 4'h0 && eng_reg[g].rep_cnt == 4'h0)
      else $error("load did not restart sequence");

    a_load_captures: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      load[g] |=> eng_reg[g].first_code == $past(regs_reg[g].tx_code_reg[5:0])
                  && eng_reg[g].mode == $past(regs_reg[g].tx_control_reg[1:0]))
      else $error("load captured wrong values");

    a_no_load_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      !load[g] |=> $stable(eng_reg[g].first_code) && $stable(eng_reg[g].mode))
      else $error("engine values changed without load");

    a_idle_ones: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
      idle[g] && bit_opportunity[g] |=> feac_bit[g])
      else $error("idle engine sent a zero");

    a_single_ends: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
      last_word_bit ##0 eng_reg[g].mode == MODE_SINGLE |=> idle[g])
      else $error("single mode did not end after ten codes");

    a_dual_second: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
      last_word_bit ##0 eng_reg[g].mode == MODE_DUAL && eng_reg[g].state == ENG_CODE_A
      |=> eng_reg[g].state == ENG_CODE_B)
      else $error("dual mode did not move to second code");

    a_cont_busy: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
      !idle[g] && eng_reg[g].mode == MODE_CONT && !load[g] |=> !idle[g])
      else $error("continuous mode went idle");

    a_frame_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
      !idle[g] && bit_opportunity[g] && !load[g] && eng_reg[g].bit_pos == 4'h0
      |=> !feac_bit[g] && eng_reg[g].bit_pos == 4'h1)
      else $error("codeword did not open with zero");

    a_first_c1: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
      eng_reg[g].state == ENG_CODE_A && bit_opportunity[g] && eng_reg[g].bit_pos == 4'h1
      |=> feac_bit[g] == $past(eng_reg[g].first_code[0]))
      else $error("first code bit 0 not sent as C1");

    a_idle_latch: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
      $rose(idle[g]) |=> regs_reg[g].tx_idle_latched)
      else $error("idle rise not latched");

    // helper: a one written to this port's latched idle bit
    logic clear_hit;
    assign clear_hit = wr_access && dec.hit && (dec.port == 2'(g))
                       && (dec.sel == TX_LATCHED_IDX) && apb_req.pwdata[IDLE_BIT];

    // a rise in the same cycle must win, so only a lone clear is judged
    sequence clear_without_rise;
      clear_hit && !(idle[g] && !regs_reg[g].idle_prev);
    endsequence

    sequence status_setup;
      apb_req.psel && !apb_req.penable && !apb_req.pwrite && dec.used
        && dec.port == 2'(g) && dec.sel == TX_STATE_IDX;
    endsequence

    a_dual_ends: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
      last_word_bit ##0 eng_reg[g].mode == MODE_DUAL && eng_reg[g].state == ENG_CODE_B
      |=> idle[g])
      else $error("dual mode did not end after second code");

    a_second_c1: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
      eng_reg[g].state == ENG_CODE_B && bit_opportunity[g] && eng_reg[g].bit_pos == 4'h1
      |=> feac_bit[g] == $past(eng_reg[g].second_code[0]))
      else $error("second code bit 0 not sent as C1");

    a_latch_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
      clear_without_rise |=> !regs_reg[g].tx_idle_latched)
      else $error("latched idle not cleared by a one");

    a_latch_holds: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
      regs_reg[g].tx_idle_latched && !clear_hit |=> regs_reg[g].tx_idle_latched)
      else $error("latched idle dropped without a clear");

    a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
      status_setup |=> apb_rsp.prdata[IDLE_BIT] == $past(idle[g]))
      else $error("status read did not return live idle");
  end

  // error flag comes from the setup decode; the master holds the address
  a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    apb_rsp.pready |-> apb_rsp.pslverr == !dec.hit)
    else $error("error response disagrees with decode");

endmodule // feac_transmit_controller

//--- logic/feac_tx_pkg.sv
// constants, types and register map of the FEAC codeword transmitter
package feac_tx_pkg;

  // ---------------------------------------------------------------
  // register map: printed offsets kept as word indices
  // ---------------------------------------------------------------
  localparam int          PORT_COUNT        = 4;
  localparam logic [7:0]  TX_CONTROL_IDX    = 8'hc0;
  localparam logic [7:0]  TX_CODE_IDX       = 8'hc2;
  localparam logic [7:0]  TX_STATE_IDX      = 8'hc4;
  localparam logic [7:0]  TX_LATCHED_IDX    = 8'hc6;
  localparam logic [7:0]  TX_IRQ_EN_IDX     = 8'hc8;
  localparam logic [7:0]  TX_LAST_IDX       = 8'hce;
  localparam logic [3:0]  BLOCK_NIBBLE      = 4'hc;
  localparam int          IDX_LSB           = 2;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          LOAD_BIT          = 2;
  localparam int          MODE_LSB          = 0;
  localparam int          FIRST_CODE_LSB    = 0;
  localparam int          SECOND_CODE_LSB   = 8;
  localparam int          IDLE_BIT          = 0;

  // ---------------------------------------------------------------
  // values after reset and write masks
  // ---------------------------------------------------------------
  localparam logic [15:0] CONTROL_RESET     = 16'h0800;
  localparam logic [15:0] CODE_RESET        = 16'h0000;
  localparam logic [15:0] IRQ_EN_RESET      = 16'h0000;
  localparam logic [15:0] CONTROL_MASK      = 16'h0807;
  localparam logic [15:0] CODE_MASK         = 16'h3f3f;
  localparam logic [15:0] IRQ_EN_MASK       = 16'h0001;
  localparam logic        LATCHED_RESET     = 1'b1;

  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam logic [3:0]  CODE_REPEATS      = 4'ha;
  localparam logic [3:0]  LAST_BIT_POS      = 4'hf;
  localparam logic [3:0]  FIRST_CODE_POS    = 4'h1;
  localparam logic [3:0]  LAST_CODE_POS     = 4'h6;
  localparam logic [3:0]  TRAIL_ZERO_POS    = 4'h7;

  // ---------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_DUAL   = 2'h2,
    MODE_CONT   = 2'h3
  } seq_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE   = 2'h0,
    ENG_CODE_A = 2'h1,
    ENG_CODE_B = 2'h3
  } eng_state_t;

  typedef struct packed {
    eng_state_t state;
    seq_mode_t  mode;
    logic [5:0] first_code;
    logic [5:0] second_code;
    logic [3:0] bit_pos;
    logic [3:0] rep_cnt;
  } eng_t;

  typedef struct packed {
    logic [15:0] tx_control_reg;
    logic [15:0] tx_code_reg;
    logic [15:0] tx_state_irq_enable_reg;
    logic        tx_idle_latched;
    logic        idle_prev;
  } port_regs_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage : feac_tx_pkg

//--- sim/framer_model.sv
// behavioural framer: hands out FEAC bit slots and collects the bits sent
`timescale 1ns/10ps
module framer_model
  import feac_tx_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  run,
  input  wire integer                gap,
  input  wire logic [PORT_COUNT-1:0] feac_bit,
  output logic [PORT_COUNT-1:0]      bit_opportunity
);
  // ----
  // slots and collection
  // ----
  int   cnt      = 0;
  logic was_slot = 1'b0;
  logic got[PORT_COUNT][$];

  initial bit_opportunity = '0;

  // read a cycle after the slot, once the transmitter has shifted
  always @(posedge sys_clk) begin
    if (was_slot) begin
      for (int p = 0; p < PORT_COUNT; p++) got[p].push_back(feac_bit[p]);
    end
    was_slot <= bit_opportunity[0];
    if (run && cnt + 1 >= gap) begin
      bit_opportunity <= '1;
      cnt <= 0;
    end else begin
      bit_opportunity <= '0;
      cnt <= cnt + 1;
    end
  end
endmodule // framer_model

//--- sim/test_feac_transmit_controller.sv
// self-checking bench for the FEAC codeword transmitter
`timescale 1ns/10ps
module test_feac_transmit_controller
  import feac_tx_pkg::*;
;
  logic                  sys_clk = 1'b0;
  logic                  reset_n = 1'b0;
  apb_req_t              req     = '0;
  apb_rsp_t              rsp;
  logic [PORT_COUNT-1:0] slot;
  logic [PORT_COUNT-1:0] feac_bit;
  logic                  run     = 1'b0;
  int                    gap     = 1;
  int                    mismatches   = 0;
  int                    total_checks = 0;
  int                    cycles  = 0;
  int                    seed    = 10;
  logic                  exp_bits[PORT_COUNT][$];
  logic [31:0]           rd;
  logic                  err;

  always #50 sys_clk = ~sys_clk;

  feac_transmit_controller dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .apb_req(req),
    .apb_rsp(rsp), .bit_opportunity(slot), .feac_bit(feac_bit));
  framer_model framer_u (.sys_clk(sys_clk), .run(run), .gap(gap), .feac_bit(feac_bit),
    .bit_opportunity(slot));

  // ----
  // reporting
  // ----
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, want, seen);
    end
  endtask

  // ----
  // bus and link tasks
  // ----
  task apb(input logic wr, input logic [3:0] nib, input logic [7:0] off, input logic [15:0] wd);
    @(posedge sys_clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {18'h0, nib, off, 2'h0};
    req.pwdata  <= {16'h0, wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // pready ends this wait; without it only the bench timeout would
    do begin
      @(posedge sys_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task push_word(input int p, input logic [5:0] code);
    exp_bits[p].push_back(1'b0);
    for (int i = 0; i < 6; i++) exp_bits[p].push_back(code[i]);
    exp_bits[p].push_back(1'b0);
    repeat (8) exp_bits[p].push_back(1'b1);
  endtask

  // slots stop only between edges, so every collected bit is compared
  task run_slots(input int n);
    logic want;
    gap <= 1 + ($unsigned($random(seed)) % 3);
    for (int p = 0; p < PORT_COUNT; p++) framer_u.got[p].delete();
    run <= 1'b1;
    while (framer_u.got[0].size() < n) begin
      @(posedge sys_clk);
    end
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int p = 0; p < PORT_COUNT; p++) begin
      for (int i = 0; i < framer_u.got[p].size(); i++) begin
        want = exp_bits[p].size() > 0 ? exp_bits[p].pop_front() : 1'b1;
        check("feac bit", {31'h0, framer_u.got[p][i]}, {31'h0, want});
      end
    end
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] rst_val[8];
    logic [15:0] codes;
    logic [3:0]  nib;
    int          m;
    rst_val = '{CONTROL_RESET, CODE_RESET, 16'h1, 16'h1, IRQ_EN_RESET, 16'h0, 16'h0, 16'h0};
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int p = 0; p < PORT_COUNT; p++) begin
      nib = 4'(2 * p);
      for (int r = 0; r < 8; r++) begin
        apb(1'b0, nib, 8'hc0 + 8'(2 * r), 16'h0);
        check("reset value", rd, {16'h0, rst_val[r]});
        check("no error", {31'h0, err}, 32'h0);
      end
    end
    apb(1'b0, 4'h1, TX_CONTROL_IDX, 16'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, 4'h0, TX_IRQ_EN_IDX, 16'hffff);
    apb(1'b0, 4'h0, TX_IRQ_EN_IDX, 16'h0);
    check("irq enable", rd, {16'h0, IRQ_EN_MASK});
    for (int p = 0; p < PORT_COUNT; p++) begin
      nib = 4'(2 * p);
      apb(1'b1, nib, TX_LATCHED_IDX, 16'h0);
      apb(1'b0, nib, TX_LATCHED_IDX, 16'h0);
      check("latched kept", rd, 32'h1);
      apb(1'b1, nib, TX_LATCHED_IDX, 16'h1);
      apb(1'b0, nib, TX_LATCHED_IDX, 16'h0);
      check("latched cleared", rd, 32'h0);
      codes = 16'($random(seed)) & CODE_MASK;
      apb(1'b1, nib, TX_CODE_IDX, codes);
      apb(1'b0, nib, TX_CODE_IDX, 16'h0);
      check("codes", rd, {16'h0, codes});
      apb(1'b1, nib, TX_CONTROL_IDX, 16'h3);
      apb(1'b1, nib, TX_CONTROL_IDX, 16'h7);
      exp_bits[p].delete();
      repeat (4) push_word(p, codes[5:0]);
      apb(1'b0, nib, TX_STATE_IDX, 16'h0);
      check("busy", rd, 32'h0);
      run_slots(40);
      apb(1'b0, nib, TX_LATCHED_IDX, 16'h0);
      check("latched busy", rd, 32'h0);
      // abort in mid-word with a counted sequence
      m = 1 + p % 2;
      codes = 16'($random(seed)) & CODE_MASK;
      apb(1'b1, nib, TX_CONTROL_IDX, 16'(m));
      apb(1'b1, nib, TX_CODE_IDX, codes);
      apb(1'b1, nib, TX_CONTROL_IDX, 16'(m) | 16'h4);
      exp_bits[p].delete();
      repeat (10) push_word(p, codes[5:0]);
      if (m == 2) repeat (10) push_word(p, codes[13:8]);
      apb(1'b1, nib, TX_CODE_IDX, ~codes & CODE_MASK);
      apb(1'b1, nib, TX_CONTROL_IDX, 16'h3);
      run_slots(160 * m + 24);
      apb(1'b0, nib, TX_STATE_IDX, 16'h0);
      check("idle after count", rd, 32'h1);
      apb(1'b0, nib, TX_LATCHED_IDX, 16'h0);
      check("latched idle", rd, 32'h1);
      // continuous, then idle mode
      apb(1'b1, nib, TX_LATCHED_IDX, 16'h1);
      apb(1'b1, nib, TX_CONTROL_IDX, 16'h7);
      exp_bits[p].delete();
      repeat (2) push_word(p, ~codes[5:0]);
      run_slots(20);
      apb(1'b1, nib, TX_CONTROL_IDX, 16'h0);
      apb(1'b1, nib, TX_CONTROL_IDX, 16'h4);
      exp_bits[p].delete();
      run_slots(20);
      apb(1'b0, nib, TX_LATCHED_IDX, 16'h0);
      check("latched after idle load", rd, 32'h1);
    end
    // reset while a continuous sequence is loaded but the framer hands out no slots
    apb(1'b1, 4'h0, TX_CONTROL_IDX, 16'h3);
    apb(1'b1, 4'h0, TX_CONTROL_IDX, 16'h7);
    apb(1'b1, 4'h0, TX_LATCHED_IDX, 16'h1);
    apb(1'b0, 4'h0, TX_LATCHED_IDX, 16'h0);
    check("latched before reset", rd, 32'h0);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, 4'h0, TX_LATCHED_IDX, 16'h0);
    check("latched after reset", rd, 32'h1);
    apb(1'b0, 4'h0, TX_STATE_IDX, 16'h0);
    check("idle after reset", rd, 32'h1);
    apb(1'b0, 4'h0, TX_CONTROL_IDX, 16'h0);
    check("control after reset", rd, {16'h0, CONTROL_RESET});
    conclude();
  end
endmodule // test_feac_transmit_controller
